// file: src/arf_pkg.sv
// package for the converter result buffer and host port
// assumes a single 40 MHz clock domain and a 12-bit parallel host bus
package arf_pkg;
    localparam int DATA_W = 12;
    localparam int REG_W = 10;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    // register address codes on the two top data lines
    localparam logic [1:0] ADDR_SETUP = 2'h0;
    localparam logic [1:0] ADDR_PORT = 2'h1;
    // converter_setup fields
    localparam int TEST_HI = 9;
    localparam int TEST_LO = 8;
    localparam int SCAN_BIT = 7;
    localparam int DIFF_HI = 6;
    localparam int DIFF_LO = 5;
    localparam int PICK_HI = 4;
    localparam int PICK_LO = 3;
    localparam int PD_BIT = 2;
    // buffer_and_port_setup fields
    localparam int READBACK_BIT = 9;
    localparam int CODING_BIT = 7;
    localparam int THR_HI = 3;
    localparam int THR_LO = 2;
    localparam int BUF_RST_BIT = 1;
    localparam int DEV_RST_BIT = 0;
    localparam logic [REG_W-1:0] SETUP_RESET = 10'h020;
    localparam logic [REG_W-1:0] PORT_RESET = 10'h000;
    // threshold counts for one input
    localparam logic [4:0] THR_CNT_0 = 5'h01;
    localparam logic [4:0] THR_CNT_1 = 5'h04;
    localparam logic [4:0] THR_CNT_2 = 5'h08;
    localparam logic [4:0] THR_CNT_3 = 5'h0E;
    localparam logic [DATA_W-1:0] MSB_FLIP = 12'h800;
endpackage : arf_pkg

// file: src/arf_result_fifo.sv
// result buffer, block-ready pulse and parallel host port of the converter
// assumes results arrive as offset-binary words with channel index, synchronous to clk_in;
// host pins pass two flops first, so a read strobe must stay low for at least 3 clocks
`timescale 1ns/1ps
`default_nettype none
module arf_result_fifo
    import arf_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [arf_pkg::DATA_W-1:0] res_data_in,
    input wire logic [1:0] res_chan_in,
    input wire logic res_valid_in,
    output logic res_ready_out,
    input wire logic chip_select_low_active_n_in,
    input wire logic chip_select_high_active_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [arf_pkg::DATA_W-1:0] data_in,
    output logic [arf_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n_out,
    output logic block_ready_n_out,
    output logic [arf_pkg::REG_W-1:0] converter_setup_out,
    output logic power_down_out,
    output logic overflow_out
);
    import arf_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [15:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic rd_q_ff, wr_q_ff, nxt_rd_q, nxt_wr_q;
    logic rd_act, wr_act, rd_evt, wr_evt;
    logic [DATA_W-1:0] pin_data;

    always_comb begin
        nxt_sync1 = {chip_select_low_active_n_in, chip_select_high_active_in,
                     rd_n_in, wr_n_in, data_in};
        nxt_sync2 = sync1_ff;
        pin_data = sync2_ff[DATA_W-1:0];
        rd_act = !sync2_ff[15] && sync2_ff[14] && !sync2_ff[13];
        wr_act = !sync2_ff[15] && sync2_ff[14] && !sync2_ff[12];
        nxt_rd_q = rd_act;
        nxt_wr_q = wr_act;
        rd_evt = rd_act && !rd_q_ff;
        wr_evt = wr_act && !wr_q_ff;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_ff <= 16'h0000;
            sync2_ff <= 16'h0000;
            rd_q_ff <= 1'b0;
            wr_q_ff <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            rd_q_ff <= nxt_rd_q;
            wr_q_ff <= nxt_wr_q;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [REG_W-1:0] setup_ff, port_ff, nxt_setup, nxt_port;
    logic buf_clear;

    always_comb begin
        nxt_setup = setup_ff;
        nxt_port = port_ff;
        buf_clear = 1'b0;
        if (wr_evt) begin
            unique case (pin_data[11:10])
                ADDR_SETUP: nxt_setup = pin_data[REG_W-1:0];
                ADDR_PORT: nxt_port = pin_data[REG_W-1:0];
                default: ;
            endcase
        end
        // reset and buffer-reset bits act once and clear themselves
        if (port_ff[DEV_RST_BIT]) begin
            nxt_setup = SETUP_RESET;
            nxt_port = PORT_RESET;
            buf_clear = 1'b1;
        end else if (port_ff[BUF_RST_BIT]) begin
            nxt_port[BUF_RST_BIT] = 1'b0;
            buf_clear = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            setup_ff <= SETUP_RESET;
            port_ff <= PORT_RESET;
        end else begin
            setup_ff <= nxt_setup;
            port_ff <= nxt_port;
        end
    end

    // ------------------------------------------------------------
    // threshold selection
    // ------------------------------------------------------------
    logic [2:0] n_en;
    logic [4:0] thr_base, thr_cnt;
    logic test_on;

    always_comb begin
        test_on = setup_ff[TEST_HI] || setup_ff[TEST_LO];
        // enabled inputs: one without scan, else picks+1 (differential count ignored)
        n_en = setup_ff[SCAN_BIT] ? {1'b0, setup_ff[PICK_HI:PICK_LO]} + 3'h1 : 3'h1;
        if (n_en > 3'(NUM_CH))
            n_en = 3'(NUM_CH);
        unique case (port_ff[THR_HI:THR_LO])
            2'h0: thr_base = THR_CNT_0;
            2'h1: thr_base = THR_CNT_1;
            2'h2: thr_base = THR_CNT_2;
            default: thr_base = THR_CNT_3;
        endcase
        // level 0 means one full scan; larger levels round down to whole scans
        if (port_ff[THR_HI:THR_LO] == 2'h0)
            thr_cnt = {2'h0, n_en};
        else
            thr_cnt = thr_base - (thr_base % {2'h0, n_en});
        if (thr_cnt == 5'h00)
            thr_cnt = {2'h0, n_en};
    end

    // ------------------------------------------------------------
    // two-entry input buffer
    // ------------------------------------------------------------
    logic [DATA_W+1:0] skid_ff [2];
    logic [DATA_W+1:0] nxt_skid [2];
    logic [1:0] skid_cnt_ff, nxt_skid_cnt;
    logic fifo_full, push;

    // both entries full stalls the converter side; a word offered while stalled is refused and sets the overflow flag
    always_comb begin
        nxt_skid = skid_ff;
        nxt_skid_cnt = skid_cnt_ff;
        push = (skid_cnt_ff != 2'h0) && !fifo_full;
        if (push) begin
            nxt_skid[0] = skid_ff[1];
            nxt_skid_cnt = nxt_skid_cnt - 2'h1;
        end
        if (res_valid_in && res_ready_out) begin
            nxt_skid[nxt_skid_cnt[0]] = {res_chan_in, res_data_in};
            nxt_skid_cnt = nxt_skid_cnt + 2'h1;
        end
        if (buf_clear)
            nxt_skid_cnt = 2'h0;
    end

    // ------------------------------------------------------------
    // circular buffer and pointers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff, rd_ptr_ff, thr_ptr_ff;
    logic [PTR_W-1:0] nxt_wr_ptr, nxt_rd_ptr, nxt_thr_ptr;
    logic [PTR_W:0] used_ff, nxt_used;
    logic [4:0] new_cnt_ff, nxt_new_cnt;
    logic aligned_ff, nxt_aligned, ovf_ff, nxt_ovf, pulse, pop;
    logic [DATA_W-1:0] coded, nxt_dout;
    logic started_ff, nxt_started;

    always_comb begin
        fifo_full = (used_ff == 5'(DEPTH));
        pop = rd_evt && (used_ff != 5'h00);
        coded = skid_ff[0][DATA_W-1:0];
        if (port_ff[CODING_BIT])
            coded = coded ^ MSB_FLIP;
        // binary coding passes the word as is
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_thr_ptr = thr_ptr_ff;
        nxt_used = used_ff;
        nxt_new_cnt = new_cnt_ff;
        nxt_aligned = aligned_ff;
        nxt_started = started_ff;
        nxt_ovf = ovf_ff;
        pulse = 1'b0;
        if (push) begin
            nxt_wr_ptr = started_ff ? wr_ptr_ff + 4'h1 : wr_ptr_ff;
            nxt_started = 1'b1;
            if (skid_ff[0][DATA_W+1:DATA_W] == 2'h0)
                nxt_aligned = 1'b1;
            if (nxt_aligned || skid_ff[0][DATA_W+1:DATA_W] == 2'h0) begin
                nxt_new_cnt = new_cnt_ff + 5'h01;
                if (nxt_new_cnt >= thr_cnt) begin
                    nxt_new_cnt = 5'h00;
                    nxt_thr_ptr = nxt_wr_ptr;
                    pulse = !test_on;
                end
            end
        end
        if (push && !pop)
            nxt_used = used_ff + 5'h01;
        else if (pop && !push)
            nxt_used = used_ff - 5'h01;
        if (pop)
            nxt_rd_ptr = rd_ptr_ff + 4'h1;
        if (res_valid_in && !res_ready_out)
            nxt_ovf = 1'b1;
        nxt_dout = mem_ff[rd_ptr_ff];
        if (sync2_ff[11:10] == 2'h3 && port_ff[READBACK_BIT])
            nxt_dout = {2'h0, setup_ff};
        if (buf_clear) begin
            nxt_wr_ptr = 4'h0;
            nxt_rd_ptr = 4'h0;
            nxt_thr_ptr = 4'h0;
            nxt_used = 5'h00;
            nxt_new_cnt = 5'h00;
            nxt_aligned = 1'b0;
            nxt_started = 1'b0;
            nxt_ovf = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_ff <= 4'h0;
            rd_ptr_ff <= 4'h0;
            thr_ptr_ff <= 4'h0;
            used_ff <= 5'h00;
            new_cnt_ff <= 5'h00;
            aligned_ff <= 1'b0;
            started_ff <= 1'b0;
            ovf_ff <= 1'b0;
            skid_cnt_ff <= 2'h0;
            skid_ff[0] <= 14'h0000;
            skid_ff[1] <= 14'h0000;
            res_ready_out <= 1'b0;
            data_out <= 12'h000;
            data_oe_n_out <= 1'b1;
            block_ready_n_out <= 1'b1;
            converter_setup_out <= SETUP_RESET;
            power_down_out <= 1'b0;
            overflow_out <= 1'b0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            thr_ptr_ff <= nxt_thr_ptr;
            used_ff <= nxt_used;
            new_cnt_ff <= nxt_new_cnt;
            aligned_ff <= nxt_aligned;
            started_ff <= nxt_started;
            ovf_ff <= nxt_ovf;
            skid_cnt_ff <= nxt_skid_cnt;
            skid_ff <= nxt_skid;
            res_ready_out <= (nxt_skid_cnt != 2'h2);
            // data is latched at the start of a read and held while it lasts
            if (rd_evt)
                data_out <= nxt_dout;
            data_oe_n_out <= !rd_act;
            block_ready_n_out <= !pulse;
            converter_setup_out <= setup_ff;
            power_down_out <= setup_ff[PD_BIT];
            overflow_out <= ovf_ff;
        end
    end

    // memory array has no reset; contents are valid only after a write
    always_ff @(posedge clk_in) begin
        if (push)
            mem_ff[nxt_wr_ptr] <= coded;
    end
endmodule : arf_result_fifo
`default_nettype wire

// file: sim/arf_result_fifo_asserts.sv
// checker for the result buffer host port, sees only the top module's ports
// assumes one clock domain and the three-flop host pin path
`timescale 1ns/1ps
`default_nettype none
module arf_result_fifo_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic res_valid_in,
    input wire logic res_ready_out,
    input wire logic chip_select_low_active_n_in,
    input wire logic chip_select_high_active_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [arf_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe_n_out,
    input wire logic block_ready_n_out,
    input wire logic [arf_pkg::REG_W-1:0] converter_setup_out,
    input wire logic power_down_out,
    input wire logic overflow_out
);
    import arf_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic rd_acc;
    assign rd_acc = !chip_select_low_active_n_in && chip_select_high_active_in && !rd_n_in;
    // ----------------------------------------
    // assertions and cover points
    // ----------------------------------------
    chk_pulse_one_cycle: assert property ($fell(block_ready_n_out) |=> block_ready_n_out)
        else $error("block ready low longer than one cycle");
    chk_test_quiet: assert property (|converter_setup_out[TEST_HI:TEST_LO] &&
        $past(|converter_setup_out[TEST_HI:TEST_LO]) |-> block_ready_n_out)
        else $error("block ready pulsed in test mode");
    chk_oe_gated: assert property (!data_oe_n_out |-> $past(rd_acc, 3))
        else $error("bus driven without a qualified read");
    chk_oe_release: assert property ($rose(data_oe_n_out) |-> $past(rd_n_in, 3))
        else $error("bus released while strobe low");
    chk_setup_write: assert property ($changed(converter_setup_out) |->
        !$past(wr_n_in, 3) || !$past(wr_n_in, 4))
        else $error("setup changed without a write");
    chk_pd_mirror: assert property (power_down_out == converter_setup_out[PD_BIT])
        else $error("power down output differs from its bit");
    chk_ovfl_cause: assert property ($rose(overflow_out) |->
        $past(res_valid_in && !res_ready_out) || $past(res_valid_in && !res_ready_out, 2))
        else $error("overflow without a refused word");
    chk_data_hold: assert property ($changed(data_out) |-> $fell(data_oe_n_out))
        else $error("read data changed outside a read");
    cov_pulse: cover property ($fell(block_ready_n_out));
    cov_full: cover property ($fell(res_ready_out));
    cov_ovfl: cover property ($rose(overflow_out));
endmodule // arf_result_fifo_asserts
bind arf_result_fifo arf_result_fifo_asserts chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .res_valid_in(res_valid_in), .res_ready_out(res_ready_out),
    .chip_select_low_active_n_in(chip_select_low_active_n_in),
    .chip_select_high_active_in(chip_select_high_active_in), .rd_n_in(rd_n_in),
    .wr_n_in(wr_n_in), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
    .block_ready_n_out(block_ready_n_out), .converter_setup_out(converter_setup_out),
    .power_down_out(power_down_out), .overflow_out(overflow_out));
`default_nettype wire

// file: sim/arf_host_model.sv
// host processor on the parallel bus: one read or write per strobe
// assumes calls start at a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module arf_host_model (
    input wire logic clk_in,
    input wire logic [11:0] rdata_in,
    output logic cs_n_out,
    output logic cs_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [11:0] data_out
);
    initial begin
        cs_n_out = 1'b1;
        cs_out = 1'b0;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        data_out = 12'h000;
    end
    // strobe held four clocks: the pins pass two sync flops plus one register
    task automatic xfer(input logic rd, input logic [11:0] d, output logic [11:0] q);
        cs_n_out <= 1'b0;
        cs_out <= 1'b1;
        rd_n_out <= !rd;
        wr_n_out <= rd;
        data_out <= d;
        repeat (4) @(posedge clk_in);
        q = rdata_in;
        cs_n_out <= 1'b1;
        cs_out <= 1'b0;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        data_out <= ~d; // released lines must not keep the old value
        repeat (3) @(posedge clk_in);
    endtask
endmodule // arf_host_model
`default_nettype wire

// file: sim/adc_result_fifo_host_port_bench.sv
// self-checking bench for the result buffer host port
// assumes the host model drives the bus pins and the bench feeds results
`timescale 1ns/1ps
`default_nettype none
module adc_result_fifo_host_port_bench;
    import arf_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, res_valid_in = 1'b0;
    logic [11:0] res_data_in = 12'h000, data_in, data_out, q;
    logic [1:0] res_chan_in = 2'h0;
    logic res_ready_out, data_oe_n_out, block_ready_n_out, power_down_out, overflow_out;
    logic cs_n, cs, rd_n, wr_n;
    logic [9:0] converter_setup_out;
    int n_mismatch = 0, samples_checked = 0, n_pulse = 0, cyc = 0, n_acc;
    // coding, converter word, expected read
    localparam logic [24:0] ROWS [6] = '{{1'b0, 12'hFFF, 12'hFFF}, {1'b0, 12'h800, 12'h800},
        {1'b0, 12'h000, 12'h000}, {1'b1, 12'hFFF, 12'h7FF}, {1'b1, 12'h800, 12'h000},
        {1'b1, 12'h000, 12'h800}};
    arf_result_fifo dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .res_data_in(res_data_in),
        .res_chan_in(res_chan_in), .res_valid_in(res_valid_in), .res_ready_out(res_ready_out),
        .chip_select_low_active_n_in(cs_n), .chip_select_high_active_in(cs), .rd_n_in(rd_n),
        .wr_n_in(wr_n), .data_in(data_in), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
        .block_ready_n_out(block_ready_n_out), .converter_setup_out(converter_setup_out),
        .power_down_out(power_down_out), .overflow_out(overflow_out));
    arf_host_model host_u (.clk_in(clk_in), .rdata_in(data_out), .cs_n_out(cs_n), .cs_out(cs),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .data_out(data_in));
    initial forever #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        n_pulse += (block_ready_n_out === 1'b0);
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic push(input logic [11:0] d);
        res_data_in <= d;
        res_valid_in <= 1'b1;
        do @(posedge clk_in); while (res_ready_out !== 1'b1);
        res_valid_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wreg(input logic [1:0] a, input logic [9:0] v);
        host_u.xfer(1'b0, {a, v}, q);
    endtask
    task automatic rd_chk(input logic [11:0] exp);
        host_u.xfer(1'b1, 12'h000, q);
        chk(q, exp);
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        chk({data_oe_n_out, block_ready_n_out, power_down_out, overflow_out}, 12'h00C);
        chk(converter_setup_out, 12'h020);
        foreach (ROWS[i]) begin
            wreg(ADDR_PORT, ROWS[i][24] ? 10'h080 : 10'h000);
            n_pulse = 0;
            push(ROWS[i][23:12]);
            repeat (4) @(posedge clk_in);
            chk(12'(n_pulse), 12'h001);
            rd_chk(ROWS[i][11:0]);
        end
        $display("coding table done");
        wreg(ADDR_PORT, 10'h004);
        n_pulse = 0;
        for (int k = 0; k < 3; k++) push(12'(12'h100 + k));
        repeat (4) @(posedge clk_in);
        chk(12'(n_pulse), 12'h000);
        push(12'h103);
        repeat (4) @(posedge clk_in);
        chk(12'(n_pulse), 12'h001);
        for (int k = 0; k < 4; k++) rd_chk(12'(12'h100 + k));
        $display("block of four done");
        // threshold back to one, so a missing pulse in test mode is really suppressed
        wreg(ADDR_PORT, 10'h000);
        wreg(ADDR_SETUP, 10'h124);
        wreg(2'h2, 10'h000);
        chk({power_down_out, converter_setup_out}, 12'h524);
        n_pulse = 0;
        push(12'h5A5);
        repeat (4) @(posedge clk_in);
        chk(12'(n_pulse), 12'h000);
        rd_chk(12'h5A5);
        wreg(ADDR_SETUP, 10'h020);
        wreg(ADDR_PORT, 10'h000);
        $display("test mode and reserved write done");
        n_acc = 0;
        while (res_ready_out === 1'b1 && n_acc < 40) begin
            push(12'(n_acc));
            n_acc++;
        end
        chk(12'(n_acc >= 16 && n_acc < 40), 12'h001);
        res_valid_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        res_valid_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk(overflow_out, 12'h001);
        for (int k = 0; k < n_acc; k++) rd_chk(12'(k));
        $display("fill and drain done");
        res_chan_in <= 2'h1;
        wreg(ADDR_PORT, 10'h002);
        chk(overflow_out, 12'h000);
        n_pulse = 0;
        push(12'h011);
        repeat (4) @(posedge clk_in);
        chk(12'(n_pulse), 12'h000);
        res_chan_in <= 2'h0;
        push(12'h022);
        repeat (4) @(posedge clk_in);
        chk(12'(n_pulse), 12'h001);
        $display("alignment after buffer reset done");
        report_and_stop();
    end
endmodule // adc_result_fifo_host_port_bench
`default_nettype wire
